// *** design/efsg_map.svh ***
// Register offsets, field positions, reset values and codes of the fault and start guard block
// Assumes a single AHB-Lite slave decoded by the system, word registers only
`ifndef EFSG_MAP_SVH
`define EFSG_MAP_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define EFSG_OFF_FUNC     12'h000
`define EFSG_OFF_POL      12'h004
`define EFSG_OFF_CTRL     12'h008
`define EFSG_OFF_STATE    12'h00C
`define EFSG_OFF_ERROR    12'h010
`define EFSG_OFF_IRQ_STAT 12'h014
`define EFSG_OFF_IRQ_MASK 12'h018
`define EFSG_OFF_HISTORY  12'h01C

// ****************************************
// Function codes and error codes
// ****************************************
`define EFSG_FUNC_EXT_FAULT 5'd12
`define EFSG_FUNC_GUARD     5'd13
`define EFSG_ERR_NONE       8'h00
`define EFSG_ERR_EXT        8'h0C
`define EFSG_ERR_GUARD      8'h0D

// ****************************************
// Field positions
// ****************************************
`define EFSG_FUNC_W      5
`define EFSG_CTRL_RESET  0
`define EFSG_CTRL_ENABLE 1
`define EFSG_IRQ_EXT     0
`define EFSG_IRQ_GUARD   1
`define EFSG_IRQ_CLEAR   2

// ****************************************
// Reset values
// ****************************************
// Third terminal starts as the start guard: the power-up check runs before software can
// program the function select, so a zero default would leave the guard unreachable
`define EFSG_FUNC_RESET 25'h000_3400
`define EFSG_POL_RESET  5'h00
`define EFSG_CTRL_INIT  2'h2
`define EFSG_MASK_RESET 3'h0

`endif

// *** design/efsg_pkg.sv ***
// Types shared by the fault and start guard block
// Assumes the constants of efsg_map.svh
package efsg_pkg;

    typedef enum logic [1:0] {
        EFSG_STOP,
        EFSG_RUN,
        EFSG_EXT_TRIP,
        EFSG_GUARD_TRIP
    } efsg_state_type;

    typedef struct packed {
        logic [4:0] terminal;
        logic forward_run_command;
        logic reverse_run_command;
        logic fault_clear_terminal;
        logic keypad_reset;
    } efsg_inputs_type;

    typedef struct packed {
        logic motor_drive;
        logic alarm;
        logic [7:0] error_code;
    } efsg_outputs_type;

endpackage

// *** design/efsg_guard.sv ***
// Fault latch and power-up start guard of a motor drive controller, AHB-Lite register slave
// Assumes terminal inputs synchronous to hclk and hresetn applied at every power-up
//
// Contract
// RQ1 - Fault input rising edge trips, E12, stops output
// RQ2 - Fault trip latches until reset or power cycle
// RQ3 - Fault trip coasts motor, alarm at once
// RQ4 - Reset clears alarm, error; run resumes after
// RQ5 - Function 12 on any terminal selects fault
// RQ6 - Falling fault edge never trips; history kept
// RQ7 - Guarded fault clear needs fresh run edge
// RQ8 - Unguarded run at power-up starts immediately
// RQ9 - Guarded run at power-up trips E13, alarm
// RQ10 - Guard alarm clears on run off, reset
// RQ11 - Guard reset with run held restarts output
// RQ12 - Function 13 selects start guard behaviour
// RQ13 - Run applied after power-up starts normally
// RQ14 - Per-terminal polarity selects active-low contacts
// RQ15 - Inputs edge-detected, one trip per edge
// RQ16 - Active error code readable until cleared
//
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "efsg_map.svh"

module efsg_guard (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire efsg_pkg::efsg_inputs_type pins,
    output efsg_pkg::efsg_outputs_type drive,
    output logic irq
);
    import efsg_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [5*`EFSG_FUNC_W-1:0] function_select;
    logic [4:0] polarity_select;
    logic [1:0] ctrl;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [7:0] history;
    efsg_state_type state;
    efsg_state_type next_state;
    logic powerup;
    logic [4:0] term_q;
    logic run_q;
    logic clear_q;

    // ****************************************
    // Terminal decoding
    // ****************************************
    function automatic logic func_active(input logic [5*`EFSG_FUNC_W-1:0] sel,
                                         input logic [4:0] lvl,
                                         input logic [4:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < 5; i++) begin
            if (sel[i*`EFSG_FUNC_W +: `EFSG_FUNC_W] == code && lvl[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    logic [4:0] term_lvl;
    logic [4:0] term_rise;
    logic ext_rise;
    logic guard_on;
    logic run_cmd;
    logic run_rise;
    logic clear_cmd;
    logic clear_fall;

    assign term_lvl = pins.terminal ^ polarity_select; // RQ14
    assign term_rise = term_lvl & ~term_q; // RQ15
    assign ext_rise = func_active(function_select, term_rise, `EFSG_FUNC_EXT_FAULT); // RQ5 RQ6
    assign guard_on = func_active(function_select, term_lvl, `EFSG_FUNC_GUARD); // RQ12
    assign run_cmd = pins.forward_run_command | pins.reverse_run_command;
    assign run_rise = run_cmd & ~run_q;
    assign clear_cmd = pins.fault_clear_terminal | pins.keypad_reset | ctrl[`EFSG_CTRL_RESET];
    assign clear_fall = ~clear_cmd & clear_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            term_q <= 5'h00;
            run_q <= 1'b0;
            clear_q <= 1'b0;
        end else begin
            term_q <= term_lvl;
            run_q <= run_cmd;
            clear_q <= clear_cmd;
        end
    end

    // ****************************************
    // Drive state machine
    // ****************************************
    // One cycle after release the power-up check runs; it sees run_cmd as held at power-up
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            powerup <= 1'b1;
        end else begin
            powerup <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            EFSG_STOP: begin
                if (ext_rise) begin
                    next_state = EFSG_EXT_TRIP; // RQ1
                end else if (powerup && run_cmd) begin
                    next_state = guard_on ? EFSG_GUARD_TRIP : EFSG_RUN; // RQ8 RQ9
                end else if (run_rise || (run_cmd && clear_fall)) begin
                    next_state = EFSG_RUN; // RQ13 RQ7
                end
            end
            EFSG_RUN: begin
                if (ext_rise) begin
                    next_state = EFSG_EXT_TRIP; // RQ1 RQ3
                end else if (!run_cmd) begin
                    next_state = EFSG_STOP;
                end
            end
            EFSG_EXT_TRIP: begin
                // Held while the clear is asserted; the release decides the restart
                if (clear_fall) begin
                    next_state = (run_cmd && !guard_on) ? EFSG_RUN : EFSG_STOP; // RQ2 RQ4 RQ7
                end
            end
            EFSG_GUARD_TRIP: begin
                if (ext_rise) begin
                    next_state = EFSG_EXT_TRIP;
                end else if (!run_cmd) begin
                    next_state = EFSG_STOP; // RQ10
                end else if (clear_cmd) begin
                    next_state = EFSG_RUN; // RQ10 RQ11
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= EFSG_STOP;
        end else begin
            state <= next_state;
        end
    end

    // Outputs from flip-flops, so alarm and coast follow the trip in the same edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive <= '0;
        end else begin
            drive.motor_drive <= (next_state == EFSG_RUN); // RQ3 RQ4
            drive.alarm <= (next_state == EFSG_EXT_TRIP) || (next_state == EFSG_GUARD_TRIP);
            unique case (next_state)
                EFSG_EXT_TRIP: drive.error_code <= `EFSG_ERR_EXT; // RQ16
                EFSG_GUARD_TRIP: drive.error_code <= `EFSG_ERR_GUARD; // RQ16
                default: drive.error_code <= `EFSG_ERR_NONE;
            endcase
        end
    end

    // Trip history: last recorded trip code, kept until a reset clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            history <= `EFSG_ERR_NONE;
        end else if (next_state == EFSG_EXT_TRIP && state != EFSG_EXT_TRIP) begin
            history <= `EFSG_ERR_EXT; // RQ6
        end else if (next_state == EFSG_GUARD_TRIP && state != EFSG_GUARD_TRIP) begin
            history <= `EFSG_ERR_GUARD;
        end else if (clear_cmd) begin
            history <= `EFSG_ERR_NONE;
        end
    end

    // ****************************************
    // AHB-Lite slave
    // ****************************************
    logic dp_write;
    logic dp_read;
    logic [11:0] dp_addr;
    logic read_stat;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign read_stat = dp_read && dp_addr == `EFSG_OFF_IRQ_STAT;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            dp_write <= hsel && hready && htrans[1] && hwrite;
            dp_read <= hsel && hready && htrans[1] && !hwrite;
            dp_addr <= haddr[11:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            function_select <= `EFSG_FUNC_RESET;
            polarity_select <= `EFSG_POL_RESET;
            ctrl <= `EFSG_CTRL_INIT;
            irq_mask <= `EFSG_MASK_RESET;
        end else if (dp_write) begin
            unique case (dp_addr)
                `EFSG_OFF_FUNC: function_select <= hwdata[5*`EFSG_FUNC_W-1:0];
                `EFSG_OFF_POL: polarity_select <= hwdata[4:0];
                `EFSG_OFF_CTRL: ctrl <= hwdata[1:0];
                `EFSG_OFF_IRQ_MASK: irq_mask <= hwdata[2:0];
                default: ;
            endcase
        end
    end

    // Read of the status word clears it, but a new event in the same cycle wins
    logic [2:0] irq_events;
    assign irq_events = {clear_fall && state == EFSG_EXT_TRIP,
                         next_state == EFSG_GUARD_TRIP && state != EFSG_GUARD_TRIP,
                         next_state == EFSG_EXT_TRIP && state != EFSG_EXT_TRIP};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= (read_stat ? 3'h0 : irq_status) | irq_events;
        end
    end

    assign irq = |(irq_status & irq_mask);

    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read) begin
            unique case (dp_addr)
                `EFSG_OFF_FUNC: hrdata = {7'h00, function_select};
                `EFSG_OFF_POL: hrdata = {27'h000_0000, polarity_select};
                `EFSG_OFF_CTRL: hrdata = {30'h0000_0000, ctrl};
                `EFSG_OFF_STATE: hrdata = {27'h000_0000, drive.alarm, drive.motor_drive,
                                           guard_on, state};
                `EFSG_OFF_ERROR: hrdata = {24'h00_0000, drive.error_code};
                `EFSG_OFF_IRQ_STAT: hrdata = {29'h0000_0000, irq_status};
                `EFSG_OFF_IRQ_MASK: hrdata = {29'h0000_0000, irq_mask};
                `EFSG_OFF_HISTORY: hrdata = {24'h00_0000, history};
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

endmodule

// *** testbench/efsg_guard_props.sv ***
// Checker of the trip outputs of the fault and start guard block
// Assumes the ports of efsg_guard; bound at the foot of this file
`timescale 1ns/1ps
module efsg_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire efsg_pkg::efsg_inputs_type pins,
    input wire efsg_pkg::efsg_outputs_type drive
);
    import efsg_pkg::*;
    wire logic clr = pins.fault_clear_terminal | pins.keypad_reset;
    wire logic run = pins.forward_run_command | pins.reverse_run_command;
    wire logic [7:0] code = drive.error_code;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence ext_held;
        (code == 8'h0C && !clr)[*2];
    endsequence
    sequence ext_freed;
        (code == 8'h0C && clr) ##1 !clr;
    endsequence
    ext_stop_a: assert property (code == 8'h0C |-> !drive.motor_drive && drive.alarm)
        else $error("fault trip with output on");
    ext_hold_a: assert property (ext_held |=> code == 8'h0C)
        else $error("fault trip lost without a clear");
    ext_free_a: assert property (ext_freed |=> code == 8'h00)
        else $error("fault trip kept after clear release");
    trip_cause_a: assert property ($rose(code == 8'h0C) |->
        $past(pins.terminal) != $past(pins.terminal, 2))
        else $error("fault trip without a terminal change");
    alarm_code_a: assert property (drive.alarm == (code != 8'h00))
        else $error("alarm disagrees with error code");
    guard_stop_a: assert property (code == 8'h0D |-> drive.alarm && !drive.motor_drive)
        else $error("guard trip with output on");
    guard_clear_a: assert property (code == 8'h0D && (!run || clr) |=> code == 8'h00)
        else $error("guard trip not cleared");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus stalled or refused");
endmodule
bind efsg_guard efsg_props chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .drive(drive));

// *** testbench/efsg_contacts.sv ***
// Contacts, keypad and run commands at the far side of the guard block
// Assumes the bench calls put() to change the contact levels
`timescale 1ns/1ps
module efsg_contacts (
    input wire logic hclk,
    output efsg_pkg::efsg_inputs_type pins
);
    import efsg_pkg::*;
    initial pins = '0;
    // Levels change just after an edge, so no sample lands on a transition
    task automatic put(input efsg_inputs_type v);
        @(posedge hclk);
        pins <= v;
    endtask
endmodule

// *** testbench/efsg_guard_bench.sv ***
// Self-checking bench of the fault and start guard block
// Assumes efsg_contacts drives the pins and the bench is the only bus master
`timescale 1ns/1ps
module efsg_guard_bench;
    import efsg_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, seed = 32'h0000_4d6a;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2;
    efsg_inputs_type pins, v;
    efsg_outputs_type drive;
    int bad_count = 0, checked = 0;
    efsg_guard uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins), .drive(drive),
        .irq(irq));
    efsg_contacts far (.hclk(hclk), .pins(pins));
    initial forever #25 hclk = ~hclk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Outputs follow one edge after the pins; one spare edge lets them settle
    task automatic sees(input logic m, input logic [7:0] c);
        repeat (2) @(posedge hclk);
        #1;
        cmp({drive.motor_drive, drive.alarm, drive.error_code}, {m, c != 8'h00, c});
    endtask
    task automatic clear_pulse(input logic kp);
        v.keypad_reset = kp;
        v.fault_clear_terminal = !kp;
        far.put(v);
        v = '{default: 1'b0, terminal: v.terminal, forward_run_command: v.forward_run_command,
            reverse_run_command: v.reverse_run_command};
        far.put(v);
    endtask
    initial begin
        #200_000;
        bad_count++;
        give_verdict();
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        v = '0;
        v.forward_run_command = rnd() & 1;
        v.reverse_run_command = !v.forward_run_command;
        far.put(v);
        @(posedge hclk);
        hresetn <= 1'b1;
        sees(1, 8'h00);
        bus(0, 12'h008, 0);
        cmp(rd, 32'h2);
        bus(1, 12'h020, rnd());
        bus(0, 12'h020, 0);
        cmp(rd, 32'h0);
        for (int k = 0; k < 5; k++) begin
            bus(1, 12'h000, 32'd12 << (5 * k));
            v.terminal[k] = 1'b1;
            far.put(v);
            sees(0, 8'h0C);
            cmp(irq, 0);
            bus(0, 12'h010, 0);
            cmp(rd, 32'h0C);
            v.terminal[k] = 1'b0;
            far.put(v);
            sees(0, 8'h0C);
            clear_pulse(k[0]);
            sees(1, 8'h00);
        end
        bus(1, 12'h000, 0);
        v.terminal[4] = 1'b1;
        far.put(v);
        bus(1, 12'h004, 32'h10);
        bus(1, 12'h000, 32'd12 << 20);
        v.terminal[4] = 1'b0;
        far.put(v);
        sees(0, 8'h0C);
        clear_pulse(1'b1);
        sees(1, 8'h00);
        bus(1, 12'h004, 0);
        bus(1, 12'h000, 32'd13 | (32'd12 << 20));
        v.terminal[0] = 1'b1;
        v.terminal[4] = 1'b1;
        far.put(v);
        sees(0, 8'h0C);
        clear_pulse(1'b0);
        sees(0, 8'h00);
        v.forward_run_command = 1'b0;
        v.reverse_run_command = 1'b0;
        far.put(v);
        v.forward_run_command = 1'b1;
        far.put(v);
        sees(1, 8'h00);
        v.terminal[4] = 1'b0;
        far.put(v);
        sees(1, 8'h00);
        bus(0, 12'h014, 0);
        bus(1, 12'h018, 32'h1);
        v.terminal[4] = 1'b1;
        far.put(v);
        sees(0, 8'h0C);
        cmp(irq, 1);
        bus(0, 12'h014, 0);
        cmp(rd & 32'h1, 32'h1);
        @(posedge hclk);
        #1;
        cmp(irq, 0);
        // Power cycles with the default guard terminal on
        v = '0;
        v.terminal[2] = 1'b1;
        v.reverse_run_command = 1'b1;
        far.put(v);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        sees(0, 8'h0D);
        bus(0, 12'h00C, 0);
        cmp(rd, 32'h17);
        clear_pulse(1'b1);
        sees(1, 8'h00);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        sees(0, 8'h0D);
        v.reverse_run_command = 1'b0;
        far.put(v);
        sees(0, 8'h00);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        sees(0, 8'h00);
        v.forward_run_command = 1'b1;
        far.put(v);
        sees(1, 8'h00);
        give_verdict();
    end
endmodule
